/* File: rtl/ast_transceiver.sv */
// Asynchronous serial transceiver with an AXI4-Lite register slave.
//
// Functional notes
// - External reset clears shifters, buffer, flags; sets line, EOC, empty.
// - A data write latches the holding register and drops buffer-empty.
// - Idle shifter loads the held character at once; empty returns high.
// - Frame is start, data bits, optional parity, then selected stop bits.
// - End-of-character rises after last stop bit time, holds till next start.
// - Serial output sends bit by bit and rests marking when idle.
// - A falling input starts reception, confirmed if low eight edges later.
// - Bit timing counts the high-to-low edges of the receive clock.
// - Received data is right justified, least significant bit on line one.
// - Data and flag pins drive only while their output enables are active.
// - Parity error is set when received parity disagrees with selection.
// - Framing error is set when the stop bit is not valid.
// - Overrun is set when a character lands while data-available is set.
// - Data-available rises when a character reaches the holding register.
// - Clearing data-available touches no other flag.
// - Active status-word enable places the five status bits on the pins.
// - A control write latches the shared character format for both paths.
// - Parity disable omits parity both ways and suppresses parity error.
// - Stop select zero gives one stop bit, one gives two.
// - Length code 00 to 11 selects five to eight data bits.
// - Parity select zero means odd parity, one means even, both directions.
`timescale 1ns/1ps

module ast_transceiver import ast_pkg::*; (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic externalResetIn,
  input wire logic txClock16x,
  input wire logic rxClock16x,
  input wire logic serialIn,
  output logic serialOut,
  output logic endOfChar,
  input wire logic rxDataOutputEnableN,
  input wire logic statusWordEnableN,
  output logic [7:0] rxDataOutputs,
  output logic rxDataOutputsOe,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  logic rstAll;
  logic [4:0] control_r, control_nxt;
  logic [7:0] awAddr_r, awAddr_nxt;
  logic [31:0] wData_r, wData_nxt;
  logic [3:0] wStrb_r, wStrb_nxt;
  logic awHave_r, awHave_nxt, wHave_r, wHave_nxt;
  logic awReady_r, awReady_nxt, wReady_r, wReady_nxt;
  logic bValid_r, bValid_nxt, arReady_r, arReady_nxt;
  logic rValid_r, rValid_nxt;
  logic [1:0] bResp_r, bResp_nxt, rResp_r, rResp_nxt;
  logic [31:0] rData_r, rData_nxt;
  logic writeNow, wrControl, wrTxData, clearDataAvail;
  logic [7:0] pinData_r, pinData_nxt;
  logic pinOe_r, pinOe_nxt;
  logic evenSel, parityOff, stopTwo;
  logic [2:0] lenM1;
  logic [7:0] lenMask;
  logic [5:0] statusWord;

  ast_frame_t txState_r, txState_nxt;
  logic [7:0] holdData_r, holdData_nxt, txShift_r, txShift_nxt;
  logic holdFull_r, holdFull_nxt, txParity_r, txParity_nxt;
  logic [3:0] txTick_r, txTick_nxt;
  logic [2:0] txBit_r, txBit_nxt;
  logic txStopIdx_r, txStopIdx_nxt, txClkPrev_r, txEdge;
  logic serialOut_r, serialOut_nxt, eoc_r, eoc_nxt;

  ast_frame_t rxState_r, rxState_nxt;
  logic [7:0] rxShift_r, rxShift_nxt, rxHold_r, rxHold_nxt;
  logic [7:0] rxJust;
  logic [3:0] rxTick_r, rxTick_nxt;
  logic [2:0] rxBit_r, rxBit_nxt;
  logic rxParBit_r, rxParBit_nxt, rxClkPrev_r, serialPrev_r, rxEdge;
  logic parErr_r, parErr_nxt, frameErr_r, frameErr_nxt;
  logic overrun_r, overrun_nxt, dataAvail_r, dataAvail_nxt;

  assign rstAll = sys_rst | externalResetIn;
  assign evenSel = control_r[AST_CTL_EVEN_PARITY];
  assign parityOff = control_r[AST_CTL_PARITY_DISABLE];
  assign stopTwo = control_r[AST_CTL_STOP_SELECT];
  assign lenM1 = AST_LEN_BASE_M1 +
    {1'b0, control_r[AST_CTL_LENGTH_HI:AST_CTL_LENGTH_LO]};
  assign lenMask = 8'hff >> (AST_LEN_MAX_M1 - lenM1);
  assign statusWord = {eoc_r, ~holdFull_r, dataAvail_r, overrun_r,
    frameErr_r, parErr_r};
  assign txEdge = txClock16x & ~txClkPrev_r;
  assign rxEdge = ~rxClock16x & rxClkPrev_r;
  assign rxJust = rxShift_r >> (AST_LEN_MAX_M1 - lenM1);

  assign serialOut = serialOut_r;
  assign endOfChar = eoc_r;
  assign rxDataOutputs = pinData_r;
  assign rxDataOutputsOe = pinOe_r;
  assign s_axi_awready = awReady_r;
  assign s_axi_wready = wReady_r;
  assign s_axi_bresp = bResp_r;
  assign s_axi_bvalid = bValid_r;
  assign s_axi_arready = arReady_r;
  assign s_axi_rdata = rData_r;
  assign s_axi_rresp = rResp_r;
  assign s_axi_rvalid = rValid_r;

  // ------------------------------------------------------------
  // Register bus slave
  // ------------------------------------------------------------
  assign writeNow = awHave_r & wHave_r & ~bValid_r;
  assign wrControl = writeNow & (awAddr_r == AST_OFS_CONTROL) & wStrb_r[0];
  assign wrTxData = writeNow & (awAddr_r == AST_OFS_TX_DATA) & wStrb_r[0];
  assign clearDataAvail = writeNow & (awAddr_r == AST_OFS_STATUS) &
    wStrb_r[0] & wData_r[AST_ST_DATA_AVAIL];

  always_comb begin
    control_nxt = control_r;
    awAddr_nxt = awAddr_r;
    wData_nxt = wData_r;
    wStrb_nxt = wStrb_r;
    awHave_nxt = awHave_r;
    wHave_nxt = wHave_r;
    bValid_nxt = bValid_r;
    bResp_nxt = bResp_r;
    arReady_nxt = arReady_r;
    rValid_nxt = rValid_r;
    rResp_nxt = rResp_r;
    rData_nxt = rData_r;
    if (s_axi_awvalid && awReady_r) begin
      awAddr_nxt = {s_axi_awaddr[7:2], 2'b00};
      awHave_nxt = 1'b1;
    end
    if (s_axi_wvalid && wReady_r) begin
      wData_nxt = s_axi_wdata;
      wStrb_nxt = s_axi_wstrb;
      wHave_nxt = 1'b1;
    end
    if (writeNow) begin
      awHave_nxt = 1'b0;
      wHave_nxt = 1'b0;
      bValid_nxt = 1'b1;
      bResp_nxt = AST_RESP_OKAY;
      if (awAddr_r != AST_OFS_CONTROL && awAddr_r != AST_OFS_TX_DATA &&
          awAddr_r != AST_OFS_STATUS) begin
        bResp_nxt = AST_RESP_SLVERR;
      end
    end else if (bValid_r && s_axi_bready) begin
      bValid_nxt = 1'b0;
    end
    if (wrControl) begin
      control_nxt = wData_r[4:0];
    end
    awReady_nxt = ~awHave_nxt & ~bValid_nxt;
    wReady_nxt = ~wHave_nxt & ~bValid_nxt;
    if (s_axi_arvalid && arReady_r) begin
      arReady_nxt = 1'b0;
      rValid_nxt = 1'b1;
      rResp_nxt = AST_RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        AST_OFS_CONTROL: rData_nxt = {27'h0, control_r};
        AST_OFS_RX_DATA: rData_nxt = {24'h0, rxHold_r};
        AST_OFS_STATUS: rData_nxt = {26'h0, statusWord};
        default: begin
          rData_nxt = 32'h0;
          rResp_nxt = AST_RESP_SLVERR;
        end
      endcase
    end else if (rValid_r && s_axi_rready) begin
      rValid_nxt = 1'b0;
      arReady_nxt = 1'b1;
    end
    arReady_nxt = ~rValid_nxt;
    pinOe_nxt = ~rxDataOutputEnableN | ~statusWordEnableN;
    pinData_nxt = rxHold_r;
    if (!statusWordEnableN) begin
      pinData_nxt = {3'h0, statusWord[4:0]};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      control_r <= AST_CONTROL_RESET;
      awAddr_r <= 8'h00;
      wData_r <= 32'h0;
      wStrb_r <= 4'h0;
      awHave_r <= 1'b0;
      wHave_r <= 1'b0;
      awReady_r <= 1'b0;
      wReady_r <= 1'b0;
      bValid_r <= 1'b0;
      bResp_r <= AST_RESP_OKAY;
      arReady_r <= 1'b0;
      rValid_r <= 1'b0;
      rResp_r <= AST_RESP_OKAY;
      rData_r <= 32'h0;
      pinData_r <= 8'h00;
      pinOe_r <= 1'b0;
    end else begin
      control_r <= control_nxt;
      awAddr_r <= awAddr_nxt;
      wData_r <= wData_nxt;
      wStrb_r <= wStrb_nxt;
      awHave_r <= awHave_nxt;
      wHave_r <= wHave_nxt;
      awReady_r <= awReady_nxt;
      wReady_r <= wReady_nxt;
      bValid_r <= bValid_nxt;
      bResp_r <= bResp_nxt;
      arReady_r <= arReady_nxt;
      rValid_r <= rValid_nxt;
      rResp_r <= rResp_nxt;
      rData_r <= rData_nxt;
      pinData_r <= pinData_nxt;
      pinOe_r <= pinOe_nxt;
    end
  end

  // ------------------------------------------------------------
  // Transmitter
  // ------------------------------------------------------------
  always_comb begin
    txState_nxt = txState_r;
    holdData_nxt = holdData_r;
    holdFull_nxt = holdFull_r;
    txShift_nxt = txShift_r;
    txParity_nxt = txParity_r;
    txTick_nxt = txTick_r;
    txBit_nxt = txBit_r;
    txStopIdx_nxt = txStopIdx_r;
    serialOut_nxt = serialOut_r;
    eoc_nxt = eoc_r;
    case (txState_r)
      AST_IDLE: begin
        if (holdFull_r) begin
          txShift_nxt = holdData_r;
          txParity_nxt = ^(holdData_r & lenMask) ^ ~evenSel;
          holdFull_nxt = 1'b0;
          serialOut_nxt = 1'b0;
          eoc_nxt = 1'b0;
          txTick_nxt = 4'h0;
          txState_nxt = AST_START;
        end
      end
      default: begin
        if (txEdge) begin
          txTick_nxt = txTick_r + 4'h1;
          if (txTick_r == AST_TICK_LAST) begin
            case (txState_r)
              AST_START: begin
                txState_nxt = AST_DATA;
                txBit_nxt = 3'h0;
                serialOut_nxt = txShift_r[0];
              end
              AST_DATA: begin
                txShift_nxt = {1'b0, txShift_r[7:1]};
                txBit_nxt = txBit_r + 3'h1;
                serialOut_nxt = txShift_r[1];
                if (txBit_r == lenM1) begin
                  txStopIdx_nxt = 1'b0;
                  if (parityOff) begin
                    txState_nxt = AST_STOP;
                    serialOut_nxt = 1'b1;
                  end else begin
                    txState_nxt = AST_PARITY;
                    serialOut_nxt = txParity_r;
                  end
                end
              end
              AST_PARITY: begin
                txState_nxt = AST_STOP;
                serialOut_nxt = 1'b1;
              end
              AST_STOP: begin
                if (txStopIdx_r == stopTwo) begin
                  eoc_nxt = 1'b1;
                  serialOut_nxt = 1'b1;
                  txState_nxt = AST_IDLE;
                end else begin
                  txStopIdx_nxt = 1'b1;
                end
              end
              default: txState_nxt = AST_IDLE;
            endcase
          end
        end
      end
    endcase
    if (wrTxData) begin
      holdData_nxt = wData_r[7:0];
      holdFull_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    txClkPrev_r <= txClock16x;
    if (rstAll) begin
      txState_r <= AST_IDLE;
      holdData_r <= 8'h00;
      holdFull_r <= 1'b0;
      txShift_r <= 8'h00;
      txParity_r <= 1'b0;
      txTick_r <= 4'h0;
      txBit_r <= 3'h0;
      txStopIdx_r <= 1'b0;
      serialOut_r <= 1'b1;
      eoc_r <= 1'b1;
    end else begin
      txState_r <= txState_nxt;
      holdData_r <= holdData_nxt;
      holdFull_r <= holdFull_nxt;
      txShift_r <= txShift_nxt;
      txParity_r <= txParity_nxt;
      txTick_r <= txTick_nxt;
      txBit_r <= txBit_nxt;
      txStopIdx_r <= txStopIdx_nxt;
      serialOut_r <= serialOut_nxt;
      eoc_r <= eoc_nxt;
    end
  end

  // ------------------------------------------------------------
  // Receiver
  // ------------------------------------------------------------
  always_comb begin
    rxState_nxt = rxState_r;
    rxShift_nxt = rxShift_r;
    rxHold_nxt = rxHold_r;
    rxTick_nxt = rxTick_r;
    rxBit_nxt = rxBit_r;
    rxParBit_nxt = rxParBit_r;
    parErr_nxt = parErr_r;
    frameErr_nxt = frameErr_r;
    overrun_nxt = overrun_r;
    dataAvail_nxt = dataAvail_r;
    if (clearDataAvail) begin
      dataAvail_nxt = 1'b0;
    end
    case (rxState_r)
      AST_IDLE: begin
        if (serialPrev_r && !serialIn) begin
          rxTick_nxt = 4'h0;
          rxState_nxt = AST_START;
        end
      end
      AST_START: begin
        if (rxEdge) begin
          rxTick_nxt = rxTick_r + 4'h1;
          if (rxTick_r == AST_START_CHECK_LAST) begin
            rxTick_nxt = 4'h0;
            rxBit_nxt = 3'h0;
            rxState_nxt = serialIn ? AST_IDLE : AST_DATA;
          end
        end
      end
      default: begin
        if (rxEdge) begin
          rxTick_nxt = rxTick_r + 4'h1;
          if (rxTick_r == AST_TICK_LAST) begin
            case (rxState_r)
              AST_DATA: begin
                rxShift_nxt = {serialIn, rxShift_r[7:1]};
                rxBit_nxt = rxBit_r + 3'h1;
                if (rxBit_r == lenM1) begin
                  rxState_nxt = parityOff ? AST_STOP : AST_PARITY;
                end
              end
              AST_PARITY: begin
                rxParBit_nxt = serialIn;
                rxState_nxt = AST_STOP;
              end
              AST_STOP: begin
                rxHold_nxt = rxJust;
                frameErr_nxt = ~serialIn;
                parErr_nxt = ~parityOff &
                  (^(rxJust & lenMask) ^ rxParBit_r ^ ~evenSel);
                overrun_nxt = dataAvail_r & ~clearDataAvail;
                dataAvail_nxt = 1'b1;
                rxState_nxt = AST_IDLE;
              end
              default: rxState_nxt = AST_IDLE;
            endcase
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    rxClkPrev_r <= rxClock16x;
    serialPrev_r <= serialIn;
    if (rstAll) begin
      rxState_r <= AST_IDLE;
      rxShift_r <= 8'h00;
      rxHold_r <= 8'h00;
      rxTick_r <= 4'h0;
      rxBit_r <= 3'h0;
      rxParBit_r <= 1'b0;
      parErr_r <= 1'b0;
      frameErr_r <= 1'b0;
      overrun_r <= 1'b0;
      dataAvail_r <= 1'b0;
    end else begin
      rxState_r <= rxState_nxt;
      rxShift_r <= rxShift_nxt;
      rxHold_r <= rxHold_nxt;
      rxTick_r <= rxTick_nxt;
      rxBit_r <= rxBit_nxt;
      rxParBit_r <= rxParBit_nxt;
      parErr_r <= parErr_nxt;
      frameErr_r <= frameErr_nxt;
      overrun_r <= overrun_nxt;
      dataAvail_r <= dataAvail_nxt;
    end
  end

endmodule : ast_transceiver

/* File: rtl/ast_pkg.sv */
// Package with register map, field layout and timing constants.
package ast_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] AST_OFS_CONTROL = 8'h00;
  localparam logic [7:0] AST_OFS_TX_DATA = 8'h04;
  localparam logic [7:0] AST_OFS_RX_DATA = 8'h08;
  localparam logic [7:0] AST_OFS_STATUS = 8'h0c;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int AST_CTL_EVEN_PARITY = 0;
  localparam int AST_CTL_LENGTH_LO = 1;
  localparam int AST_CTL_LENGTH_HI = 2;
  localparam int AST_CTL_STOP_SELECT = 3;
  localparam int AST_CTL_PARITY_DISABLE = 4;
  localparam int AST_ST_PARITY_ERR = 0;
  localparam int AST_ST_FRAMING_ERR = 1;
  localparam int AST_ST_OVERRUN = 2;
  localparam int AST_ST_DATA_AVAIL = 3;
  localparam int AST_ST_TX_EMPTY = 4;
  localparam int AST_ST_END_OF_CHAR = 5;

  // ------------------------------------------------------------
  // Reset values and encodings
  // ------------------------------------------------------------
  localparam logic [4:0] AST_CONTROL_RESET = 5'h00;
  localparam logic [2:0] AST_LEN_BASE_M1 = 3'h4;
  localparam logic [2:0] AST_LEN_MAX_M1 = 3'h7;
  localparam logic [1:0] AST_RESP_OKAY = 2'h0;
  localparam logic [1:0] AST_RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------
  // Timing in 16x clock edges
  // ------------------------------------------------------------
  localparam logic [3:0] AST_TICK_LAST = 4'hf;
  localparam logic [3:0] AST_START_CHECK_LAST = 4'h7;

  typedef enum logic [2:0] {
    AST_IDLE, AST_START, AST_DATA, AST_PARITY, AST_STOP
  } ast_frame_t;

endpackage : ast_pkg

/* File: test/ast_transceiver_sva.sv */
// Checker for the serial transceiver ports.
`timescale 1ns/1ps
module ast_transceiver_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic externalResetIn,
  input wire logic rxDataOutputEnableN,
  input wire logic statusWordEnableN,
  input wire logic serialOut,
  input wire logic endOfChar,
  input wire logic rxDataOutputsOe,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence wrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rdTaken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  reset_mark_a: assert property (disable iff (1'b0)
    sys_rst |=> serialOut && endOfChar)
    else $error("line not idle after reset");
  path_reset_a: assert property (
    externalResetIn |=> serialOut && endOfChar)
    else $error("path reset failed");
  idle_mark_a: assert property (
    endOfChar |-> serialOut) else $error("line not marking while idle");
  start_bit_a: assert property (
    $fell(endOfChar) |-> !serialOut [*8]) else $error("start bit missing");
  oe_on_a: assert property (
    (!rxDataOutputEnableN || !statusWordEnableN) |=> rxDataOutputsOe)
    else $error("pins not driven");
  oe_off_a: assert property (
    (rxDataOutputEnableN && statusWordEnableN) |=> !rxDataOutputsOe)
    else $error("pins driven while disabled");
  wr_resp_a: assert property (
    wrTaken |-> ##[1:2] s_axi_bvalid) else $error("no write response");
  rd_resp_a: assert property (
    rdTaken |=> s_axi_rvalid) else $error("no read response");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
endmodule : ast_transceiver_chk

/* File: test/ast_term_model.sv */
// Terminal model on the far side of the serial line.
`timescale 1ns/1ps
module ast_term_model #(parameter int BIT_CYC = 64) (
  input wire logic clk,
  input wire logic lineIn,
  output logic lineOut
);
  initial lineOut = 1'b1;
  task automatic sendFrame(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      lineOut <= f[i];
      repeat (BIT_CYC - 1) @(posedge clk);
    end
    @(posedge clk);
    lineOut <= 1'b1;
  endtask : sendFrame
  task automatic pulseLow(input int cyc);
    @(posedge clk);
    lineOut <= 1'b0;
    repeat (cyc) @(posedge clk);
    lineOut <= 1'b1;
  endtask : pulseLow
  task automatic recvFrame(input int n, output logic [11:0] f);
    f = '1;
    @(negedge lineIn);
    repeat (BIT_CYC / 2) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      f[i] = lineIn;
      if (i < n - 1) repeat (BIT_CYC) @(posedge clk);
    end
  endtask : recvFrame
endmodule : ast_term_model

/* File: test/tb_top.sv */
// Self-checking bench for the serial transceiver.
`timescale 1ns/1ps
module tb_top import ast_pkg::*; ();
  logic clk = 1'b0;
  logic sysRst = 1'b1;
  logic extReset = 1'b0, dataEnN = 1'b1, statusEnN = 1'b1;
  logic [1:0] div16 = 2'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  wire serialIn, serialOut, endOfChar, oe, awready, wready, bvalid;
  wire arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [7:0] pins;
  wire [31:0] rdata;
  int failures = 0, testsRun = 0, cycles = 0;
  logic [4:0] fmts [4] = '{5'h00, 5'h03, 5'h0c, 5'h17};
  logic [7:0] dats [4] = '{8'hb5, 8'h6c, 8'h3a, 8'hc9};

  always #5 clk = ~clk;
  always @(posedge clk) div16 <= div16 + 2'h1;

  ast_transceiver dut (.clk(clk), .sys_rst(sysRst),
    .externalResetIn(extReset), .txClock16x(div16[1]),
    .rxClock16x(div16[0] ^ div16[1]), .serialIn(serialIn),
    .serialOut(serialOut), .endOfChar(endOfChar),
    .rxDataOutputEnableN(dataEnN), .statusWordEnableN(statusEnN),
    .rxDataOutputs(pins), .rxDataOutputsOe(oe), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  ast_term_model term (.clk(clk), .lineIn(serialOut), .lineOut(serialIn));

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      $display("FAIL %0t timeout", $time);
      complete_run();
    end
  end

  task automatic complete_run;
    if (failures == 0 && testsRun > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run

  task automatic cmp(input logic [31:0] got, exp, input string what);
    testsRun++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp

  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  // data held through strobe
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b1;
    do begin
      @(posedge clk);
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    cmp({30'h0, bresp}, {30'h0, er}, "bresp");
  endtask : axiWrite

  task automatic checkReg(input logic [7:0] a, input logic [31:0] e,
                          input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b1;
    do begin
      @(posedge clk);
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    cmp({30'h0, rresp}, {30'h0, er}, "rresp");
    if (er == AST_RESP_OKAY) cmp(rdata, e, "rdata");
  endtask : checkReg

  function automatic int nbits(input logic [4:0] c);
    return 5 + int'(c[2:1]);
  endfunction : nbits

  function automatic int flen(input logic [4:0] c);
    return 2 + nbits(c) + int'(!c[4]) + int'(c[3]);
  endfunction : flen

  function automatic logic [11:0] mkFrame(input logic [4:0] c,
                                          input logic [7:0] d);
    logic [11:0] f;
    logic p;
    f = '1;
    f[0] = 1'b0;
    p = ~c[0];
    for (int i = 0; i < nbits(c); i++) begin
      f[1+i] = d[i];
      p ^= d[i];
    end
    if (!c[4]) f[1+nbits(c)] = p;
    return f;
  endfunction : mkFrame

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic testReset;
    checkReg(AST_OFS_STATUS, 32'h30, AST_RESP_OKAY);
    checkReg(AST_OFS_CONTROL, 32'h0, AST_RESP_OKAY);
    checkReg(8'h10, 32'h0, AST_RESP_SLVERR);
    checkReg(AST_OFS_TX_DATA, 32'h0, AST_RESP_SLVERR);
    axiWrite(AST_OFS_RX_DATA, 32'h0, AST_RESP_SLVERR);
  endtask : testReset

  task automatic testGlitch;
    term.pulseLow(12);
    repeat (1000) @(posedge clk);
    checkReg(AST_OFS_STATUS, 32'h30, AST_RESP_OKAY);
  endtask : testGlitch

  task automatic testFormat(input logic [4:0] c, input logic [7:0] d);
    logic [11:0] f;
    logic [7:0] m;
    m = 8'hff >> (8 - nbits(c));
    fork
      begin
        term.recvFrame(flen(c), f);
        cmp({20'h0, f}, {20'h0, mkFrame(c, d)}, "frame");
        term.recvFrame(flen(c), f);
        cmp({20'h0, f}, {20'h0, mkFrame(c, ~d)}, "frame");
      end
      begin
        axiWrite(AST_OFS_CONTROL, {27'h0, c}, AST_RESP_OKAY);
        axiWrite(AST_OFS_TX_DATA, {24'h0, d}, AST_RESP_OKAY);
        axiWrite(AST_OFS_TX_DATA, {24'h0, ~d}, AST_RESP_OKAY);
        checkReg(AST_OFS_STATUS, 32'h0, AST_RESP_OKAY);
      end
    join
    repeat (100) @(posedge clk);
    checkReg(AST_OFS_STATUS, 32'h30, AST_RESP_OKAY);
    term.sendFrame(mkFrame(c, d), flen(c));
    checkReg(AST_OFS_STATUS, 32'h38, AST_RESP_OKAY);
    checkReg(AST_OFS_RX_DATA, {24'h0, d & m}, AST_RESP_OKAY);
    dataEnN <= 1'b0;
    repeat (2) @(posedge clk);
    cmp({23'h0, oe, pins}, {23'h0, 1'b1, d & m}, "pins");
    dataEnN <= 1'b1;
    axiWrite(AST_OFS_STATUS, 32'h8, AST_RESP_OKAY);
    checkReg(AST_OFS_STATUS, 32'h30, AST_RESP_OKAY);
  endtask : testFormat

  task automatic testErrors;
    logic [11:0] f;
    axiWrite(AST_OFS_CONTROL, 32'h0, AST_RESP_OKAY);
    f = mkFrame(5'h00, 8'h0a);
    f[6] = ~f[6];
    term.sendFrame(f, 8);
    checkReg(AST_OFS_STATUS, 32'h39, AST_RESP_OKAY);
    term.sendFrame(mkFrame(5'h00, 8'h0b), 8);
    checkReg(AST_OFS_STATUS, 32'h3c, AST_RESP_OKAY);
    statusEnN <= 1'b0;
    repeat (2) @(posedge clk);
    cmp({27'h0, pins[4:0]}, 32'h1c, "status pins");
    statusEnN <= 1'b1;
    axiWrite(AST_OFS_STATUS, 32'h8, AST_RESP_OKAY);
    checkReg(AST_OFS_STATUS, 32'h34, AST_RESP_OKAY);
    f = mkFrame(5'h00, 8'h0a);
    f[7] = 1'b0;
    term.sendFrame(f, 8);
    checkReg(AST_OFS_STATUS, 32'h3a, AST_RESP_OKAY);
    @(posedge clk);
    extReset <= 1'b1;
    repeat (2) @(posedge clk);
    extReset <= 1'b0;
    checkReg(AST_OFS_STATUS, 32'h30, AST_RESP_OKAY);
    checkReg(AST_OFS_RX_DATA, 32'h0, AST_RESP_OKAY);
  endtask : testErrors

  initial begin
    repeat (4) @(posedge clk);
    sysRst <= 1'b0;
    testReset();
    testGlitch();
    for (int i = 0; i < 4; i++) testFormat(fmts[i], dats[i]);
    testErrors();
    complete_run();
  end
endmodule : tb_top

bind ast_transceiver ast_transceiver_chk chk (.clk(clk), .sys_rst(sys_rst),
  .externalResetIn(externalResetIn),
  .rxDataOutputEnableN(rxDataOutputEnableN),
  .statusWordEnableN(statusWordEnableN), .serialOut(serialOut),
  .endOfChar(endOfChar), .rxDataOutputsOe(rxDataOutputsOe),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));
